// ==== core/rtc_alarm_and_trim.sv ====
// alarm compare, repeat, interrupt, pulse output and per-minute trim of the clock
//
// The register addresses and register access over APB were decided locally.
module rtc_alarm_and_trim (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        half_sec_tick,
  input  wire logic        sec_tick,
  input  wire logic        timer_on,
  input  wire logic        clock_sync_flag,
  input  wire logic [6:0]  cur_second,
  input  wire logic [6:0]  cur_minute,
  input  wire logic [5:0]  cur_hour,
  input  wire logic [2:0]  cur_weekday,
  input  wire logic [5:0]  cur_day,
  input  wire logic [4:0]  cur_month,
  output logic             irq,
  output logic             alarm_pulse,
  output logic signed [9:0] trim_count,
  output logic             trim_apply
);

  // ***********************************
  // state
  // ***********************************
  rtc_alarm_pkg::bus_state_t state_reg;
  rtc_alarm_pkg::bus_state_t state_next;
  rtc_alarm_pkg::interval_t  interval;
  logic        enable_reg;
  logic        endless_repeat_bit_reg;
  logic [3:0]  mask_reg;
  logic [1:0]  ptr_reg;
  logic [7:0]  rpt_reg;
  logic [7:0]  trim_reg;
  logic        status_reg;
  logic        status_next;
  logic        irq_mask_reg;
  logic        pulse_reg;
  logic [31:0] rdata_mux;
  logic        addr_ok;
  logic        commit;
  logic        wr_cfg;
  logic        acc_high;
  logic        wr_high;
  logic        wr_low;
  logic        rd_status;
  logic [15:0] mem_rdata;
  logic [47:0] words;
  logic [15:0] w_minsec;
  logic [15:0] w_wdhr;
  logic [15:0] w_mthdy;
  logic        m_sec_one;
  logic        m_sec_ten;
  logic        m_min_one;
  logic        m_min_ten;
  logic        m_hour;
  logic        m_wday;
  logic        m_day;
  logic        m_month;
  logic        match;
  logic        tick;
  logic        alarm_event;

  // ***********************************
  // bus decode
  // ***********************************
  // commit marks the access edge at which pready is high; every write and
  // every read side effect happens there and nowhere else
  assign commit    = (state_reg == rtc_alarm_pkg::BUS_ANSWER) && psel && penable;
  assign wr_cfg    = commit && pwrite && (paddr == rtc_alarm_pkg::OFS_ALARM_CFG);
  assign acc_high  = commit && (paddr == rtc_alarm_pkg::OFS_VAL_HIGH);
  assign wr_high   = acc_high && pwrite;
  assign wr_low    = commit && pwrite && (paddr == rtc_alarm_pkg::OFS_VAL_LOW);
  assign rd_status = commit && !pwrite && (paddr == rtc_alarm_pkg::OFS_IRQ_STATUS);

  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      rtc_alarm_pkg::OFS_ALARM_CFG,
      rtc_alarm_pkg::OFS_VAL_HIGH,
      rtc_alarm_pkg::OFS_VAL_LOW,
      rtc_alarm_pkg::OFS_TRIM,
      rtc_alarm_pkg::OFS_IRQ_STATUS,
      rtc_alarm_pkg::OFS_IRQ_MASK,
      rtc_alarm_pkg::OFS_STATUS: addr_ok = 1'b1;
      default:                   addr_ok = 1'b0;
    endcase
  end

  // read data, reserved bits zero
  always_comb begin
    rdata_mux = 32'h0000_0000;
    case (paddr)
      rtc_alarm_pkg::OFS_ALARM_CFG: begin
        rdata_mux[rtc_alarm_pkg::CFG_EN_BIT]    = enable_reg;
        rdata_mux[rtc_alarm_pkg::CFG_ENDLESS_REPEAT_BIT_BIT] = endless_repeat_bit_reg;
        rdata_mux[rtc_alarm_pkg::CFG_MASK_HI:rtc_alarm_pkg::CFG_MASK_LO] = mask_reg;
        rdata_mux[rtc_alarm_pkg::CFG_PTR_HI:rtc_alarm_pkg::CFG_PTR_LO]   = ptr_reg;
        rdata_mux[rtc_alarm_pkg::CFG_RPT_HI:rtc_alarm_pkg::CFG_RPT_LO]   = rpt_reg;
      end
      rtc_alarm_pkg::OFS_VAL_HIGH:   rdata_mux[7:0] = mem_rdata[15:8];
      rtc_alarm_pkg::OFS_VAL_LOW:    rdata_mux[7:0] = mem_rdata[7:0];
      rtc_alarm_pkg::OFS_TRIM:       rdata_mux[7:0] = trim_reg;
      rtc_alarm_pkg::OFS_IRQ_STATUS: rdata_mux[rtc_alarm_pkg::IRQ_ALARM_BIT] = status_reg;
      rtc_alarm_pkg::OFS_IRQ_MASK:   rdata_mux[rtc_alarm_pkg::IRQ_ALARM_BIT] = irq_mask_reg;
      rtc_alarm_pkg::OFS_STATUS: begin
        rdata_mux[rtc_alarm_pkg::ST_PULSE_BIT] = pulse_reg;
        rdata_mux[rtc_alarm_pkg::ST_SYNC_BIT]  = clock_sync_flag;
        rdata_mux[rtc_alarm_pkg::ST_EN_BIT]    = enable_reg;
      end
      default: rdata_mux = 32'h0000_0000;
    endcase
  end

  // ***********************************
  // bus handshake: setup, fetch, answer
  // ***********************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rtc_alarm_pkg::BUS_IDLE:   if (psel && !penable) state_next = rtc_alarm_pkg::BUS_FETCH;
      rtc_alarm_pkg::BUS_FETCH:  state_next = rtc_alarm_pkg::BUS_ANSWER;
      rtc_alarm_pkg::BUS_ANSWER: if (commit || !psel) state_next = rtc_alarm_pkg::BUS_IDLE;
      default:                   state_next = rtc_alarm_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      state_reg <= rtc_alarm_pkg::BUS_IDLE;
    else
      state_reg <= state_next;
  end

  // the answer is built in the fetch cycle, so read data never reflect a
  // write or a clear made by the same transfer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (state_reg == rtc_alarm_pkg::BUS_FETCH) begin
      pready  <= 1'b1;
      pslverr <= !addr_ok;
      prdata  <= pwrite ? 32'h0000_0000 : rdata_mux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ***********************************
  // alarm value words
  // ***********************************
  // pointer value 3 selects no word: it reads zero and drops writes
  alarm_value_store #(
    .WORDS     (rtc_alarm_pkg::NUM_VAL_WORDS),
    .KEEP      (rtc_alarm_pkg::VAL_KEEP)
  ) u_values (
    .clk       (clk),
    .rst       (rst),
    .wr_index  (ptr_reg),
    .wr_high   (wr_high),
    .wr_low    (wr_low),
    .wr_byte   (pwdata[7:0]),
    .rd_index  (ptr_reg),
    .rd_data   (mem_rdata),
    .all_words (words)
  );

  assign w_minsec = words[15:0];
  assign w_wdhr   = words[31:16];
  assign w_mthdy  = words[47:32];

  // pointer: loaded by config write, stepped down by high window access
  // the floor stops the step at word 0, so repeated high accesses stay there
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      ptr_reg <= rtc_alarm_pkg::PTR_RESET;
    else if (wr_cfg)
      ptr_reg <= pwdata[rtc_alarm_pkg::CFG_PTR_HI:rtc_alarm_pkg::CFG_PTR_LO];
    else if (acc_high && ptr_reg != rtc_alarm_pkg::PTR_FLOOR)
      ptr_reg <= ptr_reg - 2'h1;
  end

  // ***********************************
  // digit compare
  // ***********************************
  assign m_sec_one = cur_second[3:0] == w_minsec[3:0];
  assign m_sec_ten = cur_second[6:4] == w_minsec[6:4];
  assign m_min_one = cur_minute[3:0] == w_minsec[11:8];
  assign m_min_ten = cur_minute[6:4] == w_minsec[14:12];
  assign m_hour    = cur_hour    == w_wdhr[5:0];
  assign m_wday    = cur_weekday == w_wdhr[10:8];
  assign m_day     = cur_day     == w_mthdy[5:0];
  assign m_month   = cur_month   == w_mthdy[12:8];
  assign interval  = rtc_alarm_pkg::interval_t'(mask_reg);

  // month mode matches the day of the month, not the weekday; the year adds
  // the month; codes above yearly never match and so never raise an alarm
  always_comb begin
    match = 1'b0;
    case (interval)
      rtc_alarm_pkg::IV_HALF_SEC: match = 1'b1;
      rtc_alarm_pkg::IV_SECOND:   match = 1'b1;
      rtc_alarm_pkg::IV_TEN_SEC:  match = m_sec_one;
      rtc_alarm_pkg::IV_MINUTE:   match = m_sec_one && m_sec_ten;
      rtc_alarm_pkg::IV_TEN_MIN:  match = m_sec_one && m_sec_ten && m_min_one;
      rtc_alarm_pkg::IV_HOUR:     match = m_sec_one && m_sec_ten && m_min_one && m_min_ten;
      rtc_alarm_pkg::IV_DAY:
        match = m_sec_one && m_sec_ten && m_min_one && m_min_ten && m_hour;
      rtc_alarm_pkg::IV_WEEK:
        match = m_sec_one && m_sec_ten && m_min_one && m_min_ten && m_hour && m_wday;
      rtc_alarm_pkg::IV_MONTH:
        match = m_sec_one && m_sec_ten && m_min_one && m_min_ten && m_hour && m_day;
      rtc_alarm_pkg::IV_YEAR:
        match = m_sec_one && m_sec_ten && m_min_one && m_min_ten && m_hour && m_day
                && m_month;
      default: match = 1'b0;
    endcase
  end

  // half-second mode looks at every half tick, all others at whole seconds
  // an event needs the enable, so a finished sequence raises nothing more
  assign tick = (interval == rtc_alarm_pkg::IV_HALF_SEC) ? half_sec_tick : sec_tick;
  assign alarm_event = enable_reg && tick && match;

  // ***********************************
  // configuration and repeat
  // ***********************************
  // a config write in the same cycle as an event wins for the config fields;
  // the status bit and the pulse still take the event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_reg <= 1'b0;
      endless_repeat_bit_reg  <= 1'b0;
      mask_reg   <= 4'h0;
      rpt_reg    <= rtc_alarm_pkg::RPT_RESET;
    end else if (wr_cfg) begin
      enable_reg <= pwdata[rtc_alarm_pkg::CFG_EN_BIT];
      endless_repeat_bit_reg  <= pwdata[rtc_alarm_pkg::CFG_ENDLESS_REPEAT_BIT_BIT];
      mask_reg   <= pwdata[rtc_alarm_pkg::CFG_MASK_HI:rtc_alarm_pkg::CFG_MASK_LO];
      rpt_reg    <= pwdata[rtc_alarm_pkg::CFG_RPT_HI:rtc_alarm_pkg::CFG_RPT_LO];
    end else if (alarm_event) begin
      if (rpt_reg != rtc_alarm_pkg::RPT_RESET)
        rpt_reg <= rpt_reg - 8'h01;
      else if (endless_repeat_bit_reg)
        rpt_reg <= rtc_alarm_pkg::RPT_WRAP;
      else
        enable_reg <= 1'b0;
    end
  end

  // ***********************************
  // interrupt and pulse
  // ***********************************
  // a read clears only the bit it returned; a new event wins
  // an event that lands after the fetch is kept for the next read
  assign status_next = (status_reg && !(rd_status && prdata[rtc_alarm_pkg::IRQ_ALARM_BIT]))
                       || alarm_event;

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      status_reg <= 1'b0;
    else
      status_reg <= status_next;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      irq_mask_reg <= 1'b0;
    else if (commit && pwrite && paddr == rtc_alarm_pkg::OFS_IRQ_MASK)
      irq_mask_reg <= pwdata[rtc_alarm_pkg::IRQ_ALARM_BIT];
  end

  // level interrupt, one cycle behind the status bit and the mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= status_reg && irq_mask_reg;
  end

  // one edge per event, so the pulse runs at half the alarm rate
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      pulse_reg <= 1'b0;
    else if (alarm_event)
      pulse_reg <= !pulse_reg;
  end

  assign alarm_pulse = pulse_reg;

  // ***********************************
  // trim
  // ***********************************
  // a trim change reaches the timer two cycles after the write; a write during a
  // minute boundary could split one correction; trim writes have no window and are taken at any time
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      trim_reg <= rtc_alarm_pkg::TRIM_RESET;
    else if (commit && pwrite && paddr == rtc_alarm_pkg::OFS_TRIM)
      trim_reg <= pwdata[7:0];
  end

  // signed count times four; negative removes pulses, positive adds them
  // trim_apply marks second zero of each minute while the timer runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trim_count <= 10'sh000;
      trim_apply <= 1'b0;
    end else begin
      trim_count <= {trim_reg, rtc_alarm_pkg::TRIM_X4_ZERO};
      trim_apply <= timer_on && sec_tick && (cur_second == rtc_alarm_pkg::SEC_ZERO);
    end
  end

endmodule // rtc_alarm_and_trim

// ==== core/rtc_alarm_pkg.sv ====
// constants, register map and types of the alarm and trim block
package rtc_alarm_pkg;

  // ***********************************
  // register map (byte addresses)
  // ***********************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_ALARM_CFG  = 8'h00;
  localparam logic [7:0] OFS_VAL_HIGH   = 8'h04;
  localparam logic [7:0] OFS_VAL_LOW    = 8'h08;
  localparam logic [7:0] OFS_TRIM       = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;

  // ***********************************
  // alarm_config_repeat fields
  // ***********************************
  localparam int unsigned CFG_EN_BIT    = 15;
  localparam int unsigned CFG_ENDLESS_REPEAT_BIT_BIT = 14;
  localparam int unsigned CFG_MASK_HI   = 13;
  localparam int unsigned CFG_MASK_LO   = 10;
  localparam int unsigned CFG_PTR_HI    = 9;
  localparam int unsigned CFG_PTR_LO    = 8;
  localparam int unsigned CFG_RPT_HI    = 7;
  localparam int unsigned CFG_RPT_LO    = 0;
  localparam logic [7:0] RPT_RESET      = 8'h00;
  localparam logic [7:0] RPT_WRAP       = 8'hff;
  localparam logic [1:0] PTR_RESET      = 2'h0;
  localparam logic [1:0] PTR_FLOOR      = 2'h0;

  // ***********************************
  // alarm value words, kept bits per word
  // ***********************************
  localparam int unsigned NUM_VAL_WORDS = 3;
  localparam logic [47:0] VAL_KEEP     = {16'h1f3f, 16'h073f, 16'h7f7f};
  localparam logic [15:0] VAL_RESET    = 16'h0000;

  // ***********************************
  // trim, status and interrupt bits
  // ***********************************
  localparam logic [7:0] TRIM_RESET   = 8'h00;
  localparam logic [1:0] TRIM_X4_ZERO = 2'b00;
  localparam logic [6:0] SEC_ZERO     = 7'h00;
  localparam int unsigned IRQ_ALARM_BIT = 0;
  localparam int unsigned ST_PULSE_BIT  = 0;
  localparam int unsigned ST_SYNC_BIT   = 1;
  localparam int unsigned ST_EN_BIT     = 2;

  typedef enum logic [3:0] {
    IV_HALF_SEC = 4'h0,
    IV_SECOND   = 4'h1,
    IV_TEN_SEC  = 4'h2,
    IV_MINUTE   = 4'h3,
    IV_TEN_MIN  = 4'h4,
    IV_HOUR     = 4'h5,
    IV_DAY      = 4'h6,
    IV_WEEK     = 4'h7,
    IV_MONTH    = 4'h8,
    IV_YEAR     = 4'h9
  } interval_t;

  typedef enum logic [2:0] {
    BUS_IDLE   = 3'b001,
    BUS_FETCH  = 3'b010,
    BUS_ANSWER = 3'b100
  } bus_state_t;

endpackage

// ==== core/alarm_value_store.sv ====
// alarm value words with byte writes and a registered read port
module alarm_value_store #(
  parameter int unsigned            WORDS = rtc_alarm_pkg::NUM_VAL_WORDS,
  parameter logic [WORDS*16-1:0]    KEEP  = rtc_alarm_pkg::VAL_KEEP
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [1:0]           wr_index,
  input  wire logic                 wr_high,
  input  wire logic                 wr_low,
  input  wire logic [7:0]           wr_byte,
  input  wire logic [1:0]           rd_index,
  output logic      [15:0]          rd_data,
  output logic      [WORDS*16-1:0]  all_words
);

  // ***********************************
  // storage
  // ***********************************
  genvar g;
  generate
    for (g = 0; g < WORDS; g++) begin : g_word
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          all_words[g*16 +: 16] <= rtc_alarm_pkg::VAL_RESET;
        end else if (wr_index == 2'(g)) begin
          if (wr_high)
            all_words[g*16+8 +: 8] <= wr_byte & KEEP[g*16+8 +: 8];
          if (wr_low)
            all_words[g*16 +: 8] <= wr_byte & KEEP[g*16 +: 8];
        end
      end
    end
  endgenerate

  // ***********************************
  // registered read, unused index reads zero
  // ***********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      rd_data <= 16'h0000;
    else if (32'(rd_index) < WORDS)
      rd_data <= all_words[rd_index*16 +: 16];
    else
      rd_data <= 16'h0000;
  end

endmodule // alarm_value_store

// ==== verification/rtc_alarm_and_trim_sva.sv ====
// assertion checker bound to the ports of the alarm and trim block
module rtc_alarm_and_trim_sva (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              half_sec_tick,
  input wire logic              sec_tick,
  input wire logic              timer_on,
  input wire logic              clock_sync_flag,
  input wire logic [6:0]        cur_second,
  input wire logic [6:0]        cur_minute,
  input wire logic [5:0]        cur_hour,
  input wire logic [2:0]        cur_weekday,
  input wire logic [5:0]        cur_day,
  input wire logic [4:0]        cur_month,
  input wire logic              irq,
  input wire logic              alarm_pulse,
  input wire logic signed [9:0] trim_count,
  input wire logic              trim_apply
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ***********************************
  // bus handshake
  // ***********************************
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    penable && !pready ##1 penable && pready;
  endsequence
  property p_answer;
    s_setup |=> s_access;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer not two cycles after setup");
  property p_one_beat;
    pready |=> !pready;
  endproperty
  a_one_beat: assert property (p_one_beat)
    else $error("ready held longer than one cycle");
  property p_write_zero;
    pready && pwrite |-> prdata == 32'h0;
  endproperty
  a_write_zero: assert property (p_write_zero)
    else $error("read data not zero on a write");
  // ***********************************
  // alarm, interrupt and trim
  // ***********************************
  property p_pulse_tick;
    $changed(alarm_pulse) |-> $past(half_sec_tick);
  endproperty
  a_pulse_tick: assert property (p_pulse_tick)
    else $error("alarm pulse moved without a tick");
  property p_irq_rise;
    $rose(irq) |-> ($past(alarm_pulse) != $past(alarm_pulse, 2))
                   || ($past(pready, 2) && $past(pwrite, 2));
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose without an alarm event");
  property p_irq_fall;
    $fell(irq) |-> $past(pready, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without a bus access");
  property p_trim_x4;
    trim_count[1:0] == rtc_alarm_pkg::TRIM_X4_ZERO;
  endproperty
  a_trim_x4: assert property (p_trim_x4)
    else $error("trim count not a multiple of four");
  property p_trim_hold;
    $changed(trim_count) |-> $past(pready, 2) && $past(pwrite, 2);
  endproperty
  a_trim_hold: assert property (p_trim_hold)
    else $error("trim count changed without a write");
  property p_apply_due;
    sec_tick && timer_on && cur_second == rtc_alarm_pkg::SEC_ZERO |=> trim_apply;
  endproperty
  a_apply_due: assert property (p_apply_due)
    else $error("trim not applied at the minute");
  property p_apply_cause;
    trim_apply |-> $past(sec_tick) && $past(timer_on) && $past(cur_second) == 7'h00;
  endproperty
  a_apply_cause: assert property (p_apply_cause)
    else $error("trim applied outside the minute");
endmodule // rtc_alarm_and_trim_sva

bind rtc_alarm_and_trim rtc_alarm_and_trim_sva chk (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .half_sec_tick, .sec_tick, .timer_on, .clock_sync_flag, .cur_second, .cur_minute,
  .cur_hour, .cur_weekday, .cur_day, .cur_month, .irq, .alarm_pulse, .trim_count, .trim_apply
);

// ==== verification/rtc_alarm_and_trim_tb.sv ====
// self-checking bench for the alarm and trim block
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module rtc_alarm_and_trim_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 5000;
  logic              clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready, pslverr, irq, alarm_pulse, trim_apply;
  logic              half_sec_tick = 1'b0, sec_tick = 1'b0, timer_on = 1'b0;
  logic              clock_sync_flag = 1'b0;
  logic [6:0]        cur_second = 7'h00, cur_minute = 7'h00;
  logic [5:0]        cur_hour = 6'h00, cur_day = 6'h00;
  logic [2:0]        cur_weekday = 3'h0;
  logic [4:0]        cur_month = 5'h00;
  logic signed [9:0] trim_count;
  logic [7:0]        tv [4] = '{8'hfb, 8'h7f, 8'h80, 8'h01};
  logic              apply_seen;
  int                err_total = 0, cmp_count = 0, cyc = 0, evt = 0, n0;

  rtc_alarm_and_trim uut (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .half_sec_tick, .sec_tick, .timer_on, .clock_sync_flag, .cur_second, .cur_minute,
    .cur_hour, .cur_weekday, .cur_day, .cur_month, .irq, .alarm_pulse, .trim_count,
    .trim_apply
  );

  initial begin
    forever #50 clk = ~clk;
  end
  // ***********************************
  // bus, tick and time tasks
  // ***********************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(q, x)
    `CHK(e, xe)
  endtask
  // a whole second also carries the half-second tick
  task automatic tick(input logic whole);
    logic p0;
    p0 = alarm_pulse;
    half_sec_tick <= 1'b1;
    sec_tick <= whole;
    @(posedge clk);
    half_sec_tick <= 1'b0;
    sec_tick <= 1'b0;
    @(posedge clk);
    apply_seen = trim_apply;
    @(posedge clk);
    if (alarm_pulse !== p0) evt++;
  endtask
  // k picks one time field that is moved off the alarm value, 0 for none
  task automatic set_time(input int k);
    cur_second <= (k == 1) ? 7'h35 : (k == 2) ? 7'h24 : 7'h34;
    cur_minute <= (k == 3) ? 7'h13 : (k == 4) ? 7'h02 : 7'h12;
    cur_hour <= (k == 5) ? 6'h22 : 6'h23;
    cur_weekday <= (k == 6) ? 3'h4 : 3'h5;
    cur_day <= (k == 7) ? 6'h16 : 6'h17;
    cur_month <= (k == 8) ? 5'h08 : 5'h09;
  endtask
  task automatic results();
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      results();
    end
  end
  // ***********************************
  // scenarios
  // ***********************************
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 8; a++) begin
      rd(8'(a * 4), 32'h0, 1'(a == 7));
    end
    wr(rtc_alarm_pkg::OFS_ALARM_CFG, 32'h0200);
    wr(rtc_alarm_pkg::OFS_VAL_LOW, 32'h17);
    wr(rtc_alarm_pkg::OFS_VAL_HIGH, 32'h09);
    wr(rtc_alarm_pkg::OFS_VAL_LOW, 32'h23);
    wr(rtc_alarm_pkg::OFS_VAL_HIGH, 32'h05);
    wr(rtc_alarm_pkg::OFS_VAL_LOW, 32'hff);
    wr(rtc_alarm_pkg::OFS_VAL_HIGH, 32'hff);
    wr(rtc_alarm_pkg::OFS_ALARM_CFG, 32'h0200);
    rd(rtc_alarm_pkg::OFS_VAL_HIGH, 32'h09, 1'b0);
    rd(rtc_alarm_pkg::OFS_VAL_LOW, 32'h23, 1'b0);
    rd(rtc_alarm_pkg::OFS_VAL_HIGH, 32'h05, 1'b0);
    rd(rtc_alarm_pkg::OFS_VAL_LOW, 32'h7f, 1'b0);
    rd(rtc_alarm_pkg::OFS_VAL_HIGH, 32'h7f, 1'b0);
    wr(rtc_alarm_pkg::OFS_VAL_LOW, 32'h34);
    wr(rtc_alarm_pkg::OFS_VAL_HIGH, 32'h12);
    rd(rtc_alarm_pkg::OFS_VAL_LOW, 32'h34, 1'b0);
    rd(rtc_alarm_pkg::OFS_VAL_HIGH, 32'h12, 1'b0);
    wr(rtc_alarm_pkg::OFS_IRQ_MASK, 32'h1);
    for (int m = 0; m < 10; m++) begin
      wr(rtc_alarm_pkg::OFS_ALARM_CFG, 32'hc000 | 32'(m << 10));
      n0 = evt;
      if (m > 1) begin
        set_time(m - 1);
        tick(1'b1);
        `CHK(evt, n0)
      end
      set_time((m == 9) ? 6 : m);
      tick(1'(m != 0));
      `CHK(evt, n0 + 1)
      `CHK(irq, 1'b1)
      rd(rtc_alarm_pkg::OFS_IRQ_STATUS, 32'h1, 1'b0);
      `CHK(irq, 1'b0)
      rd(rtc_alarm_pkg::OFS_ALARM_CFG, 32'hc0ff | 32'(m << 10), 1'b0);
    end
    wr(rtc_alarm_pkg::OFS_ALARM_CFG, 32'ha800);
    n0 = evt;
    tick(1'b1);
    `CHK(evt, n0)
    wr(rtc_alarm_pkg::OFS_IRQ_MASK, 32'h0);
    wr(rtc_alarm_pkg::OFS_ALARM_CFG, 32'h84ff);
    set_time(0);
    n0 = evt;
    tick(1'b1);
    rd(rtc_alarm_pkg::OFS_ALARM_CFG, 32'h84fe, 1'b0);
    repeat (256) tick(1'b1);
    `CHK(evt, n0 + 256)
    `CHK(irq, 1'b0)
    clock_sync_flag <= 1'b1;
    rd(rtc_alarm_pkg::OFS_STATUS, 32'h2, 1'b0);
    rd(rtc_alarm_pkg::OFS_IRQ_STATUS, 32'h1, 1'b0);
    rd(rtc_alarm_pkg::OFS_ALARM_CFG, 32'h0400, 1'b0);
    wr(rtc_alarm_pkg::OFS_ALARM_CFG, 32'h0);
    timer_on <= 1'b1;
    cur_second <= rtc_alarm_pkg::SEC_ZERO;
    for (int i = 0; i < 4; i++) begin
      tick(1'b1);
      `CHK(apply_seen, 1'b1)
      wr(rtc_alarm_pkg::OFS_TRIM, {24'h0, tv[i]});
      `CHK(trim_count, 10'($signed(tv[i]) * 4))
    end
    timer_on <= 1'b0;
    tick(1'b1);
    `CHK(apply_seen, 1'b0)
    results();
  end
endmodule // rtc_alarm_and_trim_tb
